/* File: ebrw_cfg.svh */
// Offsets, field positions and reset values of the ready wait controller
`ifndef EBRW_CFG_SVH
`define EBRW_CFG_SVH
// ===============================================
// Register byte offsets
`define EBRW_OFS_CTRL   8'h00
`define EBRW_OFS_ADDR   8'h04
`define EBRW_OFS_WDATA  8'h08
`define EBRW_OFS_CMD    8'h0C
`define EBRW_OFS_STAT   8'h10
`define EBRW_OFS_RDATA  8'h14
// ===============================================
// Control fields
`define EBRW_CTRL_RDY   0
`define EBRW_CTRL_POL   1
`define EBRW_CTRL_ASY   2
`define EBRW_CTRL_ALEN  7:4
`define EBRW_CTRL_CLEN  11:8
`define EBRW_CTRL_RST   32'h0000_0002
`define EBRW_CTRL_MASK  32'h0000_0FF7
`define EBRW_ADDR_MASK  32'h00FF_FFFF
`define EBRW_WDAT_MASK  32'h0000_FFFF
`define EBRW_WORD_ZERO  32'h0000_0000
`define EBRW_POL_RST    1'b1
// ===============================================
// Command and status fields
`define EBRW_CMD_RD     0
`define EBRW_CMD_WR     1
`define EBRW_STAT_BUSY  0
`define EBRW_STAT_WAITS 15:8
`define EBRW_ADDR_RST   24'h00_0000
`define EBRW_DATA_RST   16'h0000
`define EBRW_CNT_ZERO   4'h0
`define EBRW_CNT_ONE    4'h1
`define EBRW_WAIT_ZERO  8'h00
`define EBRW_WAIT_ONE   8'h01
`define EBRW_WAIT_MAX   8'hFF
`endif

/* File: ebrw_pkg.sv */
// Types shared by the ready wait controller modules
package ebrw_pkg;
  typedef logic [23:0] ebrw_addr_t;
  typedef logic [15:0] ebrw_data_t;
  typedef logic [3:0]  ebrw_cnt_t;
  typedef logic [7:0]  ebrw_wait_t;
  typedef enum logic [1:0] {
    EBRW_IDLE,
    EBRW_ADDR,
    EBRW_CMD,
    EBRW_RDY
  } ebrw_state_e;
endpackage

/* File: ebrw_cfg_if.sv */
// Configuration and status bundle between register file and cycle engine
`timescale 1ns/100ps
interface ebrw_cfg_if;
  logic               rdy_ctl;
  logic               pol;
  logic               async_md;
  ebrw_pkg::ebrw_cnt_t  alen;
  ebrw_pkg::ebrw_cnt_t  clen;
  ebrw_pkg::ebrw_addr_t addr;
  ebrw_pkg::ebrw_data_t wdata;
  logic               start;
  logic               wr;
  logic               busy;
  ebrw_pkg::ebrw_data_t rdata;
  ebrw_pkg::ebrw_wait_t waits;
  modport regs (output rdy_ctl, pol, async_md, alen, clen, addr, wdata,
                output start, wr, input busy, rdata, waits);
  modport core (input rdy_ctl, pol, async_md, alen, clen, addr, wdata,
                input start, wr, output busy, rdata, waits);
endinterface

/* File: ebrw_sync.sv */
// Two-flop synchroniser for pin inputs, one chain per bit
`timescale 1ns/100ps
module ebrw_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // ===============================================
  // Synchroniser chains
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_reg[gi] <= 1'b0;
          q_reg[gi]    <= 1'b0;
        end else if (ce_i) begin
          meta_reg[gi] <= d_i[gi];
          q_reg[gi]    <= meta_reg[gi];
        end
      end
    end
  endgenerate

  assign q_o = q_reg;
endmodule

/* File: ebrw_regs.sv */
// Classic Wishbone slave holding the controller's registers
`timescale 1ns/100ps
`include "ebrw_cfg.svh"
module ebrw_regs (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  ebrw_cfg_if.regs         cfg
);
  logic [31:0] ctrl_reg;
  logic [31:0] addr_reg;
  logic [31:0] wdata_reg;
  logic [31:0] dat_reg;
  logic        ack_reg;
  logic        start_reg;
  logic        wr_reg;

  // Byte-lane merge, used by the CTRL, ADDR and WDATA registers
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = n[8*b +: 8];
    end
    return r;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // ===============================================
  // Decode
  wire        req     = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire        wreq    = req & wb_we_i;
  wire        cmd_wr  = wreq & hit(wb_adr_i, `EBRW_OFS_CMD) & wb_sel_i[0];
  wire [31:0] stat_w  = {16'h0000, cfg.waits, 7'h00, cfg.busy};
  wire [31:0] rd_mux  =
    hit(wb_adr_i, `EBRW_OFS_CTRL)  ? ctrl_reg :
    hit(wb_adr_i, `EBRW_OFS_ADDR)  ? addr_reg :
    hit(wb_adr_i, `EBRW_OFS_WDATA) ? wdata_reg :
    hit(wb_adr_i, `EBRW_OFS_STAT)  ? stat_w :
    hit(wb_adr_i, `EBRW_OFS_RDATA) ? {16'h0000, cfg.rdata} : 32'h0000_0000;
  // Start ignored while a bus cycle runs
  wire        go      = cmd_wr & ~cfg.busy & ~start_reg &
                        (wb_dat_i[`EBRW_CMD_RD] | wb_dat_i[`EBRW_CMD_WR]);

  // ===============================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg  <= `EBRW_CTRL_RST;
      addr_reg  <= `EBRW_WORD_ZERO;
      wdata_reg <= `EBRW_WORD_ZERO;
      dat_reg   <= `EBRW_WORD_ZERO;
      ack_reg   <= 1'b0;
      start_reg <= 1'b0;
      wr_reg    <= 1'b0;
    end else if (ce_i) begin
      ack_reg   <= req;
      dat_reg   <= req ? rd_mux : 32'h0000_0000;
      start_reg <= go;
      if (go) wr_reg <= wb_dat_i[`EBRW_CMD_WR];
      if (wreq && hit(wb_adr_i, `EBRW_OFS_CTRL))
        ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i) & `EBRW_CTRL_MASK;
      if (wreq && hit(wb_adr_i, `EBRW_OFS_ADDR))
        addr_reg <= merge(addr_reg, wb_dat_i, wb_sel_i) & `EBRW_ADDR_MASK;
      if (wreq && hit(wb_adr_i, `EBRW_OFS_WDATA))
        wdata_reg <= merge(wdata_reg, wb_dat_i, wb_sel_i) & `EBRW_WDAT_MASK;
    end
  end

  assign wb_ack_o     = ack_reg;
  assign wb_dat_o     = dat_reg;
  assign cfg.rdy_ctl  = ctrl_reg[`EBRW_CTRL_RDY];
  assign cfg.pol      = ctrl_reg[`EBRW_CTRL_POL];
  assign cfg.async_md = ctrl_reg[`EBRW_CTRL_ASY];
  assign cfg.alen     = ctrl_reg[`EBRW_CTRL_ALEN];
  assign cfg.clen     = ctrl_reg[`EBRW_CTRL_CLEN];
  assign cfg.addr     = addr_reg[23:0];
  assign cfg.wdata    = wdata_reg[15:0];
  assign cfg.start    = start_reg;
  assign cfg.wr       = wr_reg;
endmodule

/* File: ebrw_top.sv */
// External bus cycle engine with ready-controlled wait states
`timescale 1ns/100ps
`include "ebrw_cfg.svh"
// Summary of operation
// - Software selects which ready level counts active
// - Synchronous mode samples ready at reference edges
// - Asynchronous mode adds synchroniser, one wait minimum
// - First sampling point follows programmed phase lengths
// - Inactive ready inserts one wait phase, resample
// - Active ready ends the running bus cycle
// - Asynchronous sampling point lies one phase later
// - Mandatory command waits finish before ready evaluation
// - Read data captured at strobe rising edge
module ebrw_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ref_clk_i,
  input  wire logic        ext_ready_i,
  input  wire logic [15:0] ext_data_i,
  output logic      [15:0] ext_data_o,
  output logic             ext_data_oe_n_o,
  output logic      [23:0] ext_addr_o,
  output logic             ext_rd_n_o,
  output logic             ext_wr_n_o
);
  ebrw_cfg_if cfg ();

  // ===============================================
  // Register file
  ebrw_regs u_regs (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .cfg      (cfg.regs)
  );

  // ===============================================
  // Pin synchronisers
  logic [17:0] pin_s;

  ebrw_sync #(.W(18)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   ({ref_clk_i, ext_ready_i, ext_data_i}),
    .q_o   (pin_s)
  );

  wire                 ref_s  = pin_s[17];
  wire                 rdy_s  = pin_s[16];
  ebrw_pkg::ebrw_data_t data_s;
  assign data_s = pin_s[15:0];

  // ===============================================
  // State
  ebrw_pkg::ebrw_state_e state_reg, state_next;
  ebrw_pkg::ebrw_cnt_t   cnt_reg, cnt_next;
  ebrw_pkg::ebrw_cnt_t   clen_reg, clen_next;
  ebrw_pkg::ebrw_wait_t  waits_reg, waits_next;
  ebrw_pkg::ebrw_addr_t  addr_reg, addr_next;
  ebrw_pkg::ebrw_data_t  dout_reg, dout_next;
  ebrw_pkg::ebrw_data_t  rdata_reg, rdata_next;
  logic ref_d_reg;
  logic stage_reg, stage_next;
  logic rdyc_reg, rdyc_next;
  logic pol_reg, pol_next;
  logic async_reg, async_next;
  logic wrc_reg, wrc_next;
  logic busy_reg, busy_next;
  logic oe_n_reg, oe_n_next;
  logic rd_n_reg, rd_n_next;
  logic wr_n_reg, wr_n_next;
  logic fin;

  // ===============================================
  // Decode
  // Phases advance on reference clock rising edges only
  wire tick      = ref_s & ~ref_d_reg;
  wire rdy_act   = (rdy_s == pol_reg);
  // async point reads the extra stage
  wire rdy_now   = async_reg ? stage_reg : rdy_act;
  wire cnt_zero  = (cnt_reg == `EBRW_CNT_ZERO);
  wire [7:0] waits_inc = (waits_reg == `EBRW_WAIT_MAX) ? waits_reg :
                         8'(waits_reg + `EBRW_WAIT_ONE);
  wire [3:0] cnt_dec   = 4'(cnt_reg - `EBRW_CNT_ONE);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    clen_next  = clen_reg;
    waits_next = waits_reg;
    addr_next  = addr_reg;
    dout_next  = dout_reg;
    rdata_next = rdata_reg;
    rdyc_next  = rdyc_reg;
    pol_next   = pol_reg;
    async_next = async_reg;
    wrc_next   = wrc_reg;
    busy_next  = busy_reg;
    oe_n_next  = oe_n_reg;
    rd_n_next  = rd_n_reg;
    wr_n_next  = wr_n_reg;
    fin        = 1'b0;
    stage_next = tick ? rdy_act : stage_reg;
    case (state_reg)
      ebrw_pkg::EBRW_IDLE: begin
        if (cfg.start) begin
          rdyc_next  = cfg.rdy_ctl;
          pol_next   = cfg.pol;
          async_next = cfg.async_md;
          clen_next  = cfg.clen;
          cnt_next   = cfg.alen;
          addr_next  = cfg.addr;
          dout_next  = cfg.wdata;
          wrc_next   = cfg.wr;
          oe_n_next  = ~cfg.wr;
          busy_next  = 1'b1;
          waits_next = `EBRW_WAIT_ZERO;
          state_next = ebrw_pkg::EBRW_ADDR;
        end
      end
      ebrw_pkg::EBRW_ADDR: begin
        if (tick && cnt_zero) begin
          rd_n_next  = wrc_reg;
          wr_n_next  = ~wrc_reg;
          cnt_next   = clen_reg;
          state_next = ebrw_pkg::EBRW_CMD;
        end else if (tick) begin
          cnt_next = cnt_dec;
        end
      end
      ebrw_pkg::EBRW_CMD: begin
        if (tick) begin
          if (!cnt_zero) begin
            cnt_next = cnt_dec;
          end else if (!rdyc_reg) begin
            fin = 1'b1;
          end else if (async_reg || !rdy_act) begin
            waits_next = waits_inc;
            state_next = ebrw_pkg::EBRW_RDY;
          end else begin
            fin = 1'b1;
          end
        end
      end
      ebrw_pkg::EBRW_RDY: begin
        if (tick) begin
          if (rdy_now) begin
            fin = 1'b1;
          end else begin
            waits_next = waits_inc;
          end
        end
      end
      default: begin
        state_next = ebrw_pkg::EBRW_IDLE;
      end
    endcase
    if (fin) begin
      rd_n_next  = 1'b1;
      wr_n_next  = 1'b1;
      oe_n_next  = 1'b1;
      busy_next  = 1'b0;
      state_next = ebrw_pkg::EBRW_IDLE;
      if (!wrc_reg) rdata_next = data_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ebrw_pkg::EBRW_IDLE;
      cnt_reg   <= `EBRW_CNT_ZERO;
      clen_reg  <= `EBRW_CNT_ZERO;
      waits_reg <= `EBRW_WAIT_ZERO;
      addr_reg  <= `EBRW_ADDR_RST;
      dout_reg  <= `EBRW_DATA_RST;
      rdata_reg <= `EBRW_DATA_RST;
      ref_d_reg <= 1'b0;
      stage_reg <= 1'b0;
      rdyc_reg  <= 1'b0;
      pol_reg   <= `EBRW_POL_RST;
      async_reg <= 1'b0;
      wrc_reg   <= 1'b0;
      busy_reg  <= 1'b0;
      oe_n_reg  <= 1'b1;
      rd_n_reg  <= 1'b1;
      wr_n_reg  <= 1'b1;
    end else if (ce_i) begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      clen_reg  <= clen_next;
      waits_reg <= waits_next;
      addr_reg  <= addr_next;
      dout_reg  <= dout_next;
      rdata_reg <= rdata_next;
      ref_d_reg <= ref_s;
      stage_reg <= stage_next;
      rdyc_reg  <= rdyc_next;
      pol_reg   <= pol_next;
      async_reg <= async_next;
      wrc_reg   <= wrc_next;
      busy_reg  <= busy_next;
      oe_n_reg  <= oe_n_next;
      rd_n_reg  <= rd_n_next;
      wr_n_reg  <= wr_n_next;
    end
  end

  assign cfg.busy        = busy_reg;
  assign cfg.rdata       = rdata_reg;
  assign cfg.waits       = waits_reg;
  assign ext_addr_o      = addr_reg;
  assign ext_data_o      = dout_reg;
  assign ext_data_oe_n_o = oe_n_reg;
  assign ext_rd_n_o      = rd_n_reg;
  assign ext_wr_n_o      = wr_n_reg;

  // ===============================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wire in_cmd = state_reg == ebrw_pkg::EBRW_CMD;
  wire in_rdy = state_reg == ebrw_pkg::EBRW_RDY;
  wire idle   = state_reg == ebrw_pkg::EBRW_IDLE;

  property p_pol_end;
    ce_i && tick && in_rdy && !async_reg && (rdy_s == pol_reg)
      |=> idle && !busy_reg;
  endproperty
  a_pol_end: assert property (p_pol_end)
    else $error("sync ready at chosen level did not end cycle");

  property p_sync_first;
    ce_i && tick && in_cmd && cnt_zero && rdyc_reg && !async_reg &&
      rdy_act |=> idle && ext_rd_n_o && ext_wr_n_o;
  endproperty
  a_sync_first: assert property (p_sync_first)
    else $error("sync ready at first point did not end cycle");

  property p_async_wait;
    ce_i && tick && in_cmd && cnt_zero && rdyc_reg && async_reg
      |=> in_rdy && waits_reg == $past(waits_reg) + 8'h01;
  endproperty
  a_async_wait: assert property (p_async_wait)
    else $error("async cycle skipped its forced wait");

  property p_addr_len;
    ce_i && tick && state_reg == ebrw_pkg::EBRW_ADDR && cnt_zero
      |=> in_cmd && (ext_rd_n_o ^ ext_wr_n_o) && cnt_reg == clen_reg;
  endproperty
  a_addr_len: assert property (p_addr_len)
    else $error("command phase not entered after address phase");

  property p_wait_ins;
    ce_i && tick && in_rdy && !rdy_now && waits_reg != 8'hFF
      |=> in_rdy && waits_reg == $past(waits_reg) + 8'h01;
  endproperty
  a_wait_ins: assert property (p_wait_ins)
    else $error("inactive ready did not add one wait");

  property p_end;
    ce_i && tick && in_rdy && rdy_now |=> idle ##1 !busy_reg;
  endproperty
  a_end: assert property (p_end)
    else $error("active ready did not end the cycle");

  property p_async_pt;
    ce_i && tick && in_rdy && async_reg && !stage_reg && rdy_act
      |=> in_rdy && !ext_rd_n_o | !ext_wr_n_o;
  endproperty
  a_async_pt: assert property (p_async_pt)
    else $error("async point used undelayed ready");

  property p_mand;
    ce_i && tick && in_cmd && !cnt_zero |=> in_cmd && cnt_reg ==
      $past(cnt_reg) - 4'h1;
  endproperty
  a_mand: assert property (p_mand)
    else $error("ready evaluated before command waits done");

  property p_rdcap;
    $rose(ext_rd_n_o) |-> rdata_reg == $past(data_s) && idle;
  endproperty
  a_rdcap: assert property (p_rdcap)
    else $error("read data not taken at strobe rise");

  property p_noctl;
    ce_i && tick && in_cmd && cnt_zero && !rdyc_reg |=> idle;
  endproperty
  a_noctl: assert property (p_noctl)
    else $error("uncontrolled cycle did not end after phases");

  c_sync_rd: cover property ($rose(ext_rd_n_o) && !async_reg && rdyc_reg);
  c_async_wr: cover property ($rose(ext_wr_n_o) && async_reg && rdyc_reg);
  c_two_waits: cover property (in_rdy && waits_reg == 8'h02);
  c_noctl: cover property ($rose(ext_rd_n_o) && !rdyc_reg);
endmodule

/* File: ebrw_resp.sv */
// Behavioural model of the external responder driving ready and read data
`timescale 1ns/100ps
module ebrw_resp (
  input  wire logic        ref_clk_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        pol_i,
  input  wire logic [3:0]  delay_i,
  input  wire logic [15:0] rd_val_i,
  output logic             ready_o,
  output logic      [15:0] data_o
);
  logic [3:0] cnt_reg = 4'h0;
  logic       seen_reg = 1'b0;
  logic       act_reg = 1'b0;
  wire        strobe_w = ~(rd_n_i & wr_n_i);
  // ===============================================
  // Ready generation
  // Strobe sampled on the rising edge so a late strobe never races us
  always @(posedge ref_clk_i) begin
    seen_reg <= strobe_w;
  end
  // ready on falling reference edge
  // Held until the strobe rises, dropped at the falling edge after seen_reg clears; delay 0 = never
  always @(negedge ref_clk_i) begin
    cnt_reg <= seen_reg ? ((cnt_reg == 4'hF) ? cnt_reg : cnt_reg + 4'h1)
                        : 4'h0;
    act_reg <= seen_reg && (delay_i != 4'h0) &&
               ({1'b0, cnt_reg} + 5'h01 >= {1'b0, delay_i});
  end
  // active level follows the selected polarity
  assign ready_o = ~(act_reg ^ pol_i);
  // Released bus shows the inverse so a stale value is never taken
  assign data_o = rd_n_i ? ~rd_val_i : rd_val_i;
endmodule

/* File: external_bus_ready_wait_control_test.sv */
// Self-checking bench for the ready wait controller
`timescale 1ns/100ps
`include "ebrw_cfg.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  mismatches++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module external_bus_ready_wait_control_test;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ref_clk = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic        ready;
  logic [15:0] din;
  logic [15:0] dout;
  logic        oe_n;
  logic [23:0] eaddr;
  logic        rd_n;
  logic        wr_n;
  logic        pol_m = 1'b1;
  logic [3:0]  dly_m = 4'h0;
  logic [15:0] rval = 16'h0000;
  logic [15:0] seen_wd;
  logic        seen_oe;
  int          mismatches = 0;
  int          checked = 0;
  int          lowcnt = 0;
  logic [31:0] q0;
  // Rows: {clen, alen, async, pol, ready ctl}, write, responder delay
  logic [11:0] t_ctl [8] = '{12'h103, 12'h003, 12'h101, 12'h107,
                             12'h205, 12'h100, 12'h333, 12'h337};
  logic        t_wr [8] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  logic [3:0]  t_d [8] = '{4'h1, 4'h4, 4'h1, 4'h1, 4'h5, 4'h0, 4'h2, 4'h2};

  always #5 clk_i = ~clk_i;
  // Free-running reference, phase unrelated to the system clock
  initial begin
    #13;
    forever #40 ref_clk = ~ref_clk;
  end

  ebrw_top i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ref_clk_i(ref_clk), .ext_ready_i(ready), .ext_data_i(din),
    .ext_data_o(dout), .ext_data_oe_n_o(oe_n), .ext_addr_o(eaddr),
    .ext_rd_n_o(rd_n), .ext_wr_n_o(wr_n)
  );

  ebrw_resp i_resp (
    .ref_clk_i(ref_clk), .rd_n_i(rd_n), .wr_n_i(wr_n), .pol_i(pol_m),
    .delay_i(dly_m), .rd_val_i(rval), .ready_o(ready), .data_o(din)
  );

  // Reference periods with a strobe low, and write data on the pins
  always @(posedge ref_clk) begin
    if (!(rd_n && wr_n)) begin
      lowcnt++;
      seen_oe = oe_n;
    end
    if (!wr_n) begin
      seen_wd = dout;
    end
  end

  task automatic results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      results();
    end
  endtask

  task automatic run(input logic [11:0] ctl, input logic wr,
                     input logic [3:0] d, input logic [15:0] v);
    logic [31:0] q;
    int c;
    int w;
    int n;
    int l0;
    c = ctl[11:8];
    // Ready first seen one tick after the responder's delay count
    if (!ctl[0]) w = 0;
    else if (ctl[2]) w = (int'(d) + 1 - c > 1) ? int'(d) + 1 - c : 1;
    else w = (int'(d) > c) ? int'(d) - c : 0;
    @(posedge clk_i);
    pol_m <= ctl[1];
    dly_m <= d;
    rval <= v;
    wb(1'b1, `EBRW_OFS_CTRL, {20'h00000, ctl}, q);
    wb(1'b1, `EBRW_OFS_ADDR, {8'h00, 8'h00, v}, q);
    wb(1'b1, `EBRW_OFS_WDATA, {16'h0000, ~v}, q);
    l0 = lowcnt;
    wb(1'b1, `EBRW_OFS_CMD, wr ? 32'h0000_0002 : 32'h0000_0001, q);
    n = 0;
    do begin
      wb(1'b0, `EBRW_OFS_STAT, 32'h0000_0000, q);
      n++;
    end while (q[`EBRW_STAT_BUSY] !== 1'b0 && n < 400);
    if (n >= 400) begin
      mismatches++;
      results();
    end
    `CHK("wait phases", 8'(w), q[`EBRW_STAT_WAITS])
    `CHK("strobe ticks", c + 1 + w, lowcnt - l0)
    `CHK("address", {8'h00, v}, eaddr)
    if (wr) begin
      `CHK("write data", ~v, seen_wd)
      `CHK("data enable", 1'b0, seen_oe)
    end else begin
      `CHK("read enable", 1'b1, seen_oe)
      wb(1'b0, `EBRW_OFS_RDATA, 32'h0000_0000, q);
      `CHK("read data", {16'h0000, v}, q)
    end
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `EBRW_OFS_CTRL, 32'h0000_0000, q0);
    `CHK("ctrl reset", `EBRW_CTRL_RST, q0)
    wb(1'b1, 8'h20, 32'hFFFF_FFFF, q0);
    wb(1'b0, 8'h20, 32'h0000_0000, q0);
    `CHK("unmapped", 32'h0000_0000, q0)
    // Back to back cycles also show ready released in time
    for (int i = 0; i < 8; i++) begin
      run(t_ctl[i], t_wr[i], t_d[i], 16'h1234 + 16'(i) * 16'h1111);
    end
    results();
  end
endmodule
